// ### pf_stage_pkg.sv
// Constants for the under power factor protection stage
package pf_stage_pkg;

    localparam int GROUPS = 8;
    localparam int GRP_W = 3;
    localparam int DLY_W = 19;
    localparam int RATIO_W = 16;

    localparam logic [2:0] LN_ON = 3'h1;
    localparam logic [2:0] LN_BLOCKED = 3'h2;
    localparam logic [2:0] LN_TEST = 3'h3;
    localparam logic [2:0] LN_TEST_BLK = 3'h4;
    localparam logic [2:0] LN_OFF = 3'h5;

    localparam logic [2:0] COND_NORMAL = 3'h0;
    localparam logic [2:0] COND_START = 3'h1;
    localparam logic [2:0] COND_TRIP = 3'h2;
    localparam logic [2:0] COND_BLOCKED = 3'h3;
    localparam logic [2:0] COND_ALARM_START = 3'h4;
    localparam logic [2:0] COND_ALARM = 3'h5;

    localparam int EV_N = 5;
    localparam int EV_ALARM_START = 0;
    localparam int EV_ALARM = 1;
    localparam int EV_START = 2;
    localparam int EV_TRIP = 3;
    localparam int EV_BLOCKED = 4;

    localparam int PATH_ALARM = 0;
    localparam int PATH_TRIP = 1;

    localparam logic [7:0] TRIP_PF_RST = 8'h50;
    localparam logic [7:0] ALARM_PF_RST = 8'h5a;
    localparam logic [7:0] PF_SET_MIN = 8'h05;
    localparam logic [7:0] PF_SET_MAX = 8'h63;
    localparam logic ALARM_MODE_RST = 1'b1;
    localparam logic [DLY_W-1:0] DLY_RST = 19'h00000;
    localparam logic [2:0] LN_RST = LN_ON;

    localparam int RELEASE_PCT = 103;
    localparam int FULL_PCT = 100;

    localparam int CLK_HZ = 250_000_000;
    localparam int STAMP_MS = 1;
    localparam int STAMP_CYC = CLK_HZ / 1000 * STAMP_MS;
    localparam int SAMPLE_MS = 5;
    localparam int PREFAULT_MS = 20;
    localparam int PREFAULT_N = PREFAULT_MS / SAMPLE_MS;

endpackage

// ### under_power_factor_stage.sv
// Under power factor protection stage
`timescale 1ns/10ps
module under_power_factor_stage
    import pf_stage_pkg::*;
#(
    parameter int MS_CYCLES = STAMP_CYC,
    parameter int PF_W = 8,
    parameter int CNT_W = 16
) (
    input wire logic CLOCK_I,
    input wire logic RESET_I,
    input wire logic PF_VALID_I,
    input wire logic [PF_W-1:0] PF_SAMPLE_I,
    input wire logic BLOCK_I,
    input wire logic [GRP_W-1:0] GROUP_SEL_I,
    input wire logic SET_WR_I,
    input wire logic [GRP_W-1:0] SET_GROUP_I,
    input wire logic SET_ALARM_MODE_I,
    input wire logic [7:0] SET_TRIP_PF_I,
    input wire logic [7:0] SET_ALARM_PF_I,
    input wire logic [DLY_W-1:0] SET_TRIP_DLY_I,
    input wire logic [DLY_W-1:0] SET_ALARM_DLY_I,
    input wire logic [2:0] LOGICAL_NODE_BEHAVIOUR_I,
    input wire logic FORCE_EN_I,
    input wire logic [2:0] FORCE_STATUS_I,
    input wire logic [EV_N-1:0] COUNT_CLR_I,
    output logic ALARM_START_O,
    output logic ALARM_O,
    output logic START_O,
    output logic TRIP_O,
    output logic BLOCKED_O,
    output logic [EV_N-1:0] EVT_ON_O,
    output logic [EV_N-1:0] EVT_OFF_O,
    output logic [31:0] EVT_STAMP_O,
    output logic [CNT_W-1:0] CNT_ALARM_START_O,
    output logic [CNT_W-1:0] CNT_ALARM_O,
    output logic [CNT_W-1:0] CNT_START_O,
    output logic [CNT_W-1:0] CNT_TRIP_O,
    output logic [CNT_W-1:0] CNT_BLOCKED_O,
    output logic [PF_W-1:0] PREFAULT_PF_O,
    output logic [2:0] CONDITION_O,
    output logic [2:0] LN_BEHAVIOUR_O,
    output logic [DLY_W-1:0] EXP_ALARM_TIME_O,
    output logic [DLY_W-1:0] ALARM_REMAIN_O,
    output logic [DLY_W-1:0] EXP_TRIP_TIME_O,
    output logic signed [DLY_W:0] TRIP_REMAIN_O,
    output logic [RATIO_W-1:0] RATIO_ALARM_O,
    output logic [RATIO_W-1:0] RATIO_TRIP_O
);

    if (MS_CYCLES < 2 || PF_W < 7 || PF_W > 8 || CNT_W < 1) begin : g_chk
        $error("under_power_factor_stage: unsupported parameter value");
    end

    ////////////////////////////////////////////////////////////////////////
    // Setting groups
    logic [7:0] trip_pf_r [GROUPS];
    logic [7:0] alarm_pf_r [GROUPS];
    logic alarm_mode_r [GROUPS];
    logic [DLY_W-1:0] trip_dly_r [GROUPS];
    logic [DLY_W-1:0] alarm_dly_r [GROUPS];
    logic [7:0] trip_pf_nxt [GROUPS];
    logic [7:0] alarm_pf_nxt [GROUPS];
    logic alarm_mode_nxt [GROUPS];
    logic [DLY_W-1:0] trip_dly_nxt [GROUPS];
    logic [DLY_W-1:0] alarm_dly_nxt [GROUPS];

    for (genvar g = 0; g < GROUPS; g++) begin : g_grp
        always_comb begin
            trip_pf_nxt[g] = trip_pf_r[g];
            alarm_pf_nxt[g] = alarm_pf_r[g];
            alarm_mode_nxt[g] = alarm_mode_r[g];
            trip_dly_nxt[g] = trip_dly_r[g];
            alarm_dly_nxt[g] = alarm_dly_r[g];
            if (SET_WR_I && SET_GROUP_I == GRP_W'(g)) begin
                if (SET_TRIP_PF_I >= PF_SET_MIN
                    && SET_TRIP_PF_I <= PF_SET_MAX) begin
                    trip_pf_nxt[g] = SET_TRIP_PF_I;
                end
                if (SET_ALARM_PF_I >= PF_SET_MIN
                    && SET_ALARM_PF_I <= PF_SET_MAX) begin
                    alarm_pf_nxt[g] = SET_ALARM_PF_I;
                end
                alarm_mode_nxt[g] = SET_ALARM_MODE_I;
                trip_dly_nxt[g] = SET_TRIP_DLY_I;
                alarm_dly_nxt[g] = SET_ALARM_DLY_I;
            end
        end
        always_ff @(posedge CLOCK_I) begin
            if (RESET_I) begin
                trip_pf_r[g] <= TRIP_PF_RST;
                alarm_pf_r[g] <= ALARM_PF_RST;
                alarm_mode_r[g] <= ALARM_MODE_RST;
                trip_dly_r[g] <= DLY_RST;
                alarm_dly_r[g] <= DLY_RST;
            end else begin
                trip_pf_r[g] <= trip_pf_nxt[g];
                alarm_pf_r[g] <= alarm_pf_nxt[g];
                alarm_mode_r[g] <= alarm_mode_nxt[g];
                trip_dly_r[g] <= trip_dly_nxt[g];
                alarm_dly_r[g] <= alarm_dly_nxt[g];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Active settings, blocking and behaviour
    logic [7:0] thr [2];
    logic [DLY_W-1:0] dly [2];
    logic path_en [2];
    logic blk;
    logic off;
    logic [15:0] pf_pct;

    always_comb begin
        thr[PATH_ALARM] = alarm_pf_r[GROUP_SEL_I];
        thr[PATH_TRIP] = trip_pf_r[GROUP_SEL_I];
        dly[PATH_ALARM] = alarm_dly_r[GROUP_SEL_I];
        dly[PATH_TRIP] = trip_dly_r[GROUP_SEL_I];
        path_en[PATH_ALARM] = alarm_mode_r[GROUP_SEL_I];
        path_en[PATH_TRIP] = 1'b1;
        blk = BLOCK_I || LOGICAL_NODE_BEHAVIOUR_I == LN_BLOCKED
            || LOGICAL_NODE_BEHAVIOUR_I == LN_TEST_BLK;
        off = LOGICAL_NODE_BEHAVIOUR_I == LN_OFF;
        pf_pct = 16'(PF_SAMPLE_I) * 16'(FULL_PCT);
    end

    ////////////////////////////////////////////////////////////////////////
    // Pick-up, blocking and definite delay per path
    logic pu_r [2];
    logic hold_r [2];
    logic st_r [2];
    logic op_r [2];
    logic [DLY_W-1:0] cnt_r [2];
    logic pu_nxt [2];
    logic hold_nxt [2];
    logic st_nxt [2];
    logic op_nxt [2];
    logic [DLY_W-1:0] cnt_nxt [2];
    logic blk_r;
    logic blk_nxt;

    for (genvar p = 0; p < 2; p++) begin : g_path
        always_comb begin
            pu_nxt[p] = pu_r[p];
            hold_nxt[p] = hold_r[p];
            st_nxt[p] = st_r[p];
            op_nxt[p] = op_r[p];
            cnt_nxt[p] = cnt_r[p];
            if (off) begin
                pu_nxt[p] = 1'b0;
                hold_nxt[p] = 1'b0;
                st_nxt[p] = 1'b0;
                op_nxt[p] = 1'b0;
                cnt_nxt[p] = '0;
            end else if (PF_VALID_I) begin
                if (pu_r[p]) begin
                    pu_nxt[p] = path_en[p] && pf_pct
                        < 16'(thr[p]) * 16'(RELEASE_PCT);
                end else begin
                    pu_nxt[p] = path_en[p]
                        && 8'(PF_SAMPLE_I) < thr[p];
                end
                hold_nxt[p] = pu_nxt[p]
                    && (hold_r[p] || (!pu_r[p] && blk));
                st_nxt[p] = pu_nxt[p] && !blk && !hold_nxt[p];
                if (!st_nxt[p] || !st_r[p]) begin
                    cnt_nxt[p] = '0;
                end else if (cnt_r[p] < dly[p]) begin
                    cnt_nxt[p] = cnt_r[p] + 1'b1;
                end
                op_nxt[p] = st_nxt[p] && cnt_nxt[p] >= dly[p];
            end
        end
        always_ff @(posedge CLOCK_I) begin
            if (RESET_I) begin
                pu_r[p] <= 1'b0;
                hold_r[p] <= 1'b0;
                st_r[p] <= 1'b0;
                op_r[p] <= 1'b0;
                cnt_r[p] <= '0;
            end else begin
                pu_r[p] <= pu_nxt[p];
                hold_r[p] <= hold_nxt[p];
                st_r[p] <= st_nxt[p];
                op_r[p] <= op_nxt[p];
                cnt_r[p] <= cnt_nxt[p];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs, forcing, condition and events
    logic [EV_N-1:0] out_r;
    logic [EV_N-1:0] out_nxt;
    logic [EV_N-1:0] on_r;
    logic [EV_N-1:0] off_r;
    logic [2:0] cond_r;
    logic [2:0] cond_nxt;
    logic [2:0] ln_r;
    logic [31:0] stamp_r;
    logic [31:0] stamp_nxt;
    logic [31:0] div_r;
    logic [31:0] div_nxt;

    always_comb begin
        blk_nxt = PF_VALID_I ? blk : blk_r;
        out_nxt[EV_ALARM_START] = st_nxt[PATH_ALARM];
        out_nxt[EV_ALARM] = op_nxt[PATH_ALARM];
        out_nxt[EV_START] = st_nxt[PATH_TRIP];
        out_nxt[EV_TRIP] = op_nxt[PATH_TRIP];
        out_nxt[EV_BLOCKED] = (pu_nxt[PATH_ALARM] || pu_nxt[PATH_TRIP])
            && blk_nxt && !off;
        if (FORCE_EN_I) begin
            out_nxt = '0;
            case (FORCE_STATUS_I)
                COND_START: out_nxt[EV_START] = 1'b1;
                COND_TRIP: out_nxt[EV_TRIP] = 1'b1;
                COND_BLOCKED: out_nxt[EV_BLOCKED] = 1'b1;
                COND_ALARM_START: out_nxt[EV_ALARM_START] = 1'b1;
                COND_ALARM: out_nxt[EV_ALARM] = 1'b1;
                default: out_nxt = '0;
            endcase
        end
        if (out_nxt[EV_TRIP]) begin
            cond_nxt = COND_TRIP;
        end else if (out_nxt[EV_ALARM]) begin
            cond_nxt = COND_ALARM;
        end else if (out_nxt[EV_START]) begin
            cond_nxt = COND_START;
        end else if (out_nxt[EV_ALARM_START]) begin
            cond_nxt = COND_ALARM_START;
        end else if (out_nxt[EV_BLOCKED]) begin
            cond_nxt = COND_BLOCKED;
        end else begin
            cond_nxt = COND_NORMAL;
        end
        div_nxt = div_r + 32'h1;
        stamp_nxt = stamp_r;
        if (div_r == 32'(MS_CYCLES - 1)) begin
            div_nxt = '0;
            stamp_nxt = stamp_r + 32'h1;
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (RESET_I) begin
            blk_r <= 1'b0;
            out_r <= '0;
            on_r <= '0;
            off_r <= '0;
            cond_r <= COND_NORMAL;
            ln_r <= LN_RST;
            stamp_r <= '0;
            div_r <= '0;
        end else begin
            blk_r <= blk_nxt;
            out_r <= out_nxt;
            on_r <= out_nxt & ~out_r;
            off_r <= ~out_nxt & out_r;
            cond_r <= cond_nxt;
            ln_r <= LOGICAL_NODE_BEHAVIOUR_I;
            stamp_r <= stamp_nxt;
            div_r <= div_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Event counters
    logic [CNT_W-1:0] evcnt_r [EV_N];
    logic [CNT_W-1:0] evcnt_nxt [EV_N];

    for (genvar e = 0; e < EV_N; e++) begin : g_cnt
        always_comb begin
            evcnt_nxt[e] = evcnt_r[e];
            if (out_nxt[e] && !out_r[e]) begin
                evcnt_nxt[e] = (COUNT_CLR_I[e] ? '0 : evcnt_r[e])
                    + 1'b1;
            end else if (COUNT_CLR_I[e]) begin
                evcnt_nxt[e] = '0;
            end
        end
        always_ff @(posedge CLOCK_I) begin
            if (RESET_I) begin
                evcnt_r[e] <= '0;
            end else begin
                evcnt_r[e] <= evcnt_nxt[e];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Prefault average, readouts and ratios
    logic [PF_W-1:0] hist_r [PREFAULT_N];
    logic [PF_W-1:0] hist_nxt [PREFAULT_N];
    logic [PF_W-1:0] pre_r;
    logic [PF_W-1:0] pre_nxt;
    logic [PF_W+1:0] hist_sum;
    logic [RATIO_W-1:0] ratio_r [2];
    logic [RATIO_W-1:0] ratio_nxt [2];
    logic [DLY_W-1:0] rem_r [2];
    logic [DLY_W-1:0] rem_nxt [2];
    logic [DLY_W-1:0] exp_r [2];

    always_comb begin
        hist_sum = '0;
        for (int i = 0; i < PREFAULT_N; i++) begin
            hist_sum = hist_sum + (PF_W+2)'(hist_r[i]);
        end
        pre_nxt = pre_r;
        if (PF_VALID_I && (out_nxt[EV_START] && !out_r[EV_START]
            || out_nxt[EV_TRIP] && !out_r[EV_TRIP])) begin
            pre_nxt = hist_sum[PF_W+1:2];
        end
        for (int i = 0; i < PREFAULT_N; i++) begin
            hist_nxt[i] = hist_r[i];
        end
        if (PF_VALID_I) begin
            hist_nxt[0] = PF_SAMPLE_I;
            for (int i = 1; i < PREFAULT_N; i++) begin
                hist_nxt[i] = hist_r[i-1];
            end
        end
        for (int p = 0; p < 2; p++) begin
            ratio_nxt[p] = ratio_r[p];
            if (PF_VALID_I) begin
                ratio_nxt[p] = pf_pct / 16'(thr[p]);
            end
            rem_nxt[p] = st_nxt[p] ? dly[p] - cnt_nxt[p] : '0;
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (RESET_I) begin
            pre_r <= '0;
            for (int i = 0; i < PREFAULT_N; i++) begin
                hist_r[i] <= '0;
            end
            for (int p = 0; p < 2; p++) begin
                ratio_r[p] <= '0;
                rem_r[p] <= '0;
                exp_r[p] <= DLY_RST;
            end
        end else begin
            pre_r <= pre_nxt;
            for (int i = 0; i < PREFAULT_N; i++) begin
                hist_r[i] <= hist_nxt[i];
            end
            for (int p = 0; p < 2; p++) begin
                ratio_r[p] <= ratio_nxt[p];
                rem_r[p] <= rem_nxt[p];
                exp_r[p] <= dly[p];
            end
        end
    end

    always_comb begin
        ALARM_START_O = out_r[EV_ALARM_START];
        ALARM_O = out_r[EV_ALARM];
        START_O = out_r[EV_START];
        TRIP_O = out_r[EV_TRIP];
        BLOCKED_O = out_r[EV_BLOCKED];
        EVT_ON_O = on_r;
        EVT_OFF_O = off_r;
        EVT_STAMP_O = stamp_r;
        CNT_ALARM_START_O = evcnt_r[EV_ALARM_START];
        CNT_ALARM_O = evcnt_r[EV_ALARM];
        CNT_START_O = evcnt_r[EV_START];
        CNT_TRIP_O = evcnt_r[EV_TRIP];
        CNT_BLOCKED_O = evcnt_r[EV_BLOCKED];
        PREFAULT_PF_O = pre_r;
        CONDITION_O = cond_r;
        LN_BEHAVIOUR_O = ln_r;
        EXP_ALARM_TIME_O = exp_r[PATH_ALARM];
        ALARM_REMAIN_O = rem_r[PATH_ALARM];
        EXP_TRIP_TIME_O = exp_r[PATH_TRIP];
        TRIP_REMAIN_O = signed'({1'b0, rem_r[PATH_TRIP]});
        RATIO_ALARM_O = ratio_r[PATH_ALARM];
        RATIO_TRIP_O = ratio_r[PATH_TRIP];
    end

endmodule // under_power_factor_stage

// ### pf_source_model.sv
// Model of the sample source and blocking matrix
`timescale 1ns/10ps
module pf_source_model (
    input wire logic clk_i,
    input wire logic req_i,
    input wire logic blk_i,
    input wire logic [7:0] pf_i,
    output logic valid_o = 1'b0,
    output logic blk_o = 1'b0,
    output logic [7:0] pf_o = 8'h00
);
    // Sample is only meaningful with the strobe; garble it otherwise
    always @(posedge clk_i) begin
        valid_o <= req_i;
        pf_o <= req_i ? pf_i : ~pf_o;
        blk_o <= req_i ? blk_i : blk_o;
    end
endmodule // pf_source_model

// ### pf_stage_assertions.sv
// Assertion checker for the under power factor stage
`timescale 1ns/10ps
module pf_stage_assertions
    import pf_stage_pkg::*;
#(
    parameter int CNT_W = 16
) (
    input wire logic CLOCK_I,
    input wire logic RESET_I,
    input wire logic PF_VALID_I,
    input wire logic BLOCK_I,
    input wire logic [2:0] LOGICAL_NODE_BEHAVIOUR_I,
    input wire logic FORCE_EN_I,
    input wire logic [2:0] FORCE_STATUS_I,
    input wire logic [EV_N-1:0] COUNT_CLR_I,
    input wire logic ALARM_START_O,
    input wire logic ALARM_O,
    input wire logic START_O,
    input wire logic TRIP_O,
    input wire logic BLOCKED_O,
    input wire logic [EV_N-1:0] EVT_ON_O,
    input wire logic [EV_N-1:0] EVT_OFF_O,
    input wire logic [31:0] EVT_STAMP_O,
    input wire logic [CNT_W-1:0] CNT_TRIP_O,
    input wire logic [2:0] CONDITION_O,
    input wire logic [2:0] LN_BEHAVIOUR_O
);
    wire [4:0] outs = {BLOCKED_O, TRIP_O, START_O, ALARM_O, ALARM_START_O};
    default clocking @(posedge CLOCK_I); endclocking
    default disable iff (RESET_I);
    ////////////////////////////////////////////////////////////////////////
    evt_on_a: assert property (
        EVT_ON_O == (outs & ~$past(outs))) else $error("on pulse wrong");
    evt_off_a: assert property (
        EVT_OFF_O == (~outs & $past(outs))) else $error("off pulse wrong");
    zero_dly_a: assert property (
        $rose(TRIP_O) && !$past(START_O) && !$past(FORCE_EN_I)
        |-> EVT_ON_O[EV_START]) else $error("trip without start");
    stamp_step_a: assert property (
        $changed(EVT_STAMP_O) && !$past(RESET_I)
        |-> EVT_STAMP_O == $past(EVT_STAMP_O) + 32'h1) else $error("stamp");
    ln_echo_a: assert property (
        !$past(RESET_I) |-> LN_BEHAVIOUR_O == $past(LOGICAL_NODE_BEHAVIOUR_I))
        else $error("behaviour echo wrong");
    force_cond_a: assert property (
        FORCE_EN_I |=> CONDITION_O == $past(FORCE_STATUS_I))
        else $error("forced condition wrong");
    start_gate_a: assert property (
        $rose(START_O) && !$past(FORCE_EN_I)
        |-> $past(PF_VALID_I) && !$past(BLOCK_I)) else $error("start gate");
    cnt_clr_a: assert property (
        COUNT_CLR_I[EV_TRIP] && !PF_VALID_I && !FORCE_EN_I
        |=> CNT_TRIP_O == '0) else $error("counter not cleared");
    trip_cond_a: assert property (
        TRIP_O |-> CONDITION_O == COND_TRIP) else $error("trip condition");
    trip_c: cover property ($rose(TRIP_O));
    blk_c: cover property ($rose(BLOCKED_O) && !FORCE_EN_I);
    force_c: cover property (FORCE_EN_I && CONDITION_O == COND_ALARM);
endmodule // pf_stage_assertions

bind under_power_factor_stage pf_stage_assertions #(.CNT_W(CNT_W)) u_chk (.*);

// ### under_power_factor_stage_tb_top.sv
// Testbench for the under power factor stage
`timescale 1ns/10ps
module under_power_factor_stage_tb_top
    import pf_stage_pkg::*;
;
    logic CLOCK_I, RESET_I, SET_WR_I, SET_ALARM_MODE_I, FORCE_EN_I;
    logic PF_VALID_I, BLOCK_I, req, blkv;
    logic ALARM_START_O, ALARM_O, START_O, TRIP_O, BLOCKED_O;
    logic [2:0] GROUP_SEL_I, SET_GROUP_I, LOGICAL_NODE_BEHAVIOUR_I, FORCE_STATUS_I;
    logic [2:0] CONDITION_O, LN_BEHAVIOUR_O;
    logic [7:0] PF_SAMPLE_I, SET_TRIP_PF_I, SET_ALARM_PF_I, PREFAULT_PF_O, pfv;
    logic [DLY_W-1:0] SET_TRIP_DLY_I, SET_ALARM_DLY_I, EXP_ALARM_TIME_O;
    logic [DLY_W-1:0] ALARM_REMAIN_O, EXP_TRIP_TIME_O;
    logic signed [DLY_W:0] TRIP_REMAIN_O;
    logic [EV_N-1:0] COUNT_CLR_I, EVT_ON_O, EVT_OFF_O;
    logic [31:0] EVT_STAMP_O;
    logic [15:0] CNT_ALARM_START_O, CNT_ALARM_O, CNT_START_O, CNT_TRIP_O;
    logic [15:0] CNT_BLOCKED_O, RATIO_ALARM_O, RATIO_TRIP_O;
    logic [9:0] evq[$];
    int errors, n_tests, cyc, skip;

    under_power_factor_stage #(.MS_CYCLES(10)) DUT (.*);
    pf_source_model src (.clk_i(CLOCK_I), .req_i(req), .blk_i(blkv),
        .pf_i(pfv), .valid_o(PF_VALID_I), .blk_o(BLOCK_I), .pf_o(PF_SAMPLE_I));

    initial begin
        CLOCK_I = 1'b0;
        forever #2 CLOCK_I = ~CLOCK_I;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic tick(int n);
        repeat (n) @(posedge CLOCK_I);
    endtask
    task automatic chk_val(string nm, logic [31:0] e, logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("ERROR %s exp %0h seen %0h", nm, e, g);
        end
    endtask
    task automatic chk_evt(logic [9:0] e, logic [9:0] g);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("ERROR events exp %0h seen %0h", e, g);
        end
    endtask
    // Note expected on/off pulses, then hand one sample to the source
    task automatic smp(logic [7:0] pf, logic blk, logic [4:0] on,
                       logic [4:0] off);
        if ({on, off} != 10'h000) begin
            evq.push_back({on, off});
        end
        tick(1);
        req <= 1'b1;
        pfv <= pf;
        blkv <= blk;
        tick(1);
        req <= 1'b0;
        tick(4);
    endtask
    task automatic wr(logic [2:0] g, logic m, logic [7:0] tp,
                      logic [DLY_W-1:0] td);
        tick(1);
        SET_WR_I <= 1'b1;
        SET_GROUP_I <= g;
        SET_ALARM_MODE_I <= m;
        SET_TRIP_PF_I <= tp;
        SET_TRIP_DLY_I <= td;
        tick(1);
        SET_WR_I <= 1'b0;
    endtask
    task automatic final_report();
        $display("Counts: %0d checks, %0d mismatches", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    always @(posedge CLOCK_I) begin
        cyc++;
        if (!RESET_I && skip == 0 && (EVT_ON_O | EVT_OFF_O) !== 5'h00) begin
            if (evq.size() == 0) begin
                chk_evt(10'h000, {EVT_ON_O, EVT_OFF_O});
            end else begin
                chk_evt(evq.pop_front(), {EVT_ON_O, EVT_OFF_O});
            end
        end
        if (cyc == 3000) begin
            errors++;
            final_report();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        int p;
        RESET_I = 1'b1;
        req = 1'b0;
        pfv = 8'h00;
        blkv = 1'b0;
        GROUP_SEL_I = 3'h0;
        SET_WR_I = 1'b0;
        SET_GROUP_I = 3'h0;
        SET_ALARM_MODE_I = 1'b1;
        SET_TRIP_PF_I = 8'h50;
        SET_ALARM_PF_I = 8'h5a;
        SET_TRIP_DLY_I = '0;
        SET_ALARM_DLY_I = '0;
        LOGICAL_NODE_BEHAVIOUR_I = 3'h1;
        FORCE_EN_I = 1'b0;
        FORCE_STATUS_I = 3'h0;
        COUNT_CLR_I = 5'h00;
        void'($urandom(32'haf387600));
        tick(10);
        RESET_I <= 1'b0;
        tick(2);
        chk_val("behaviour", 1, LN_BEHAVIOUR_O);
        chk_val("condition", COND_NORMAL, CONDITION_O);
        $display("T1 reset done");
        smp(8'h46, 1'b0, 5'h0f, 5'h00);
        chk_val("condition", COND_TRIP, CONDITION_O);
        chk_val("trip count", 1, CNT_TRIP_O);
        chk_val("start count", 1, CNT_START_O);
        chk_val("alarm count", 1, CNT_ALARM_O);
        chk_val("alarm start count", 1, CNT_ALARM_START_O);
        chk_val("alarm", 1, ALARM_O);
        chk_val("exp alarm time", 0, EXP_ALARM_TIME_O);
        chk_val("alarm left", 0, ALARM_REMAIN_O);
        chk_val("trip ratio", 87, RATIO_TRIP_O);
        chk_val("alarm ratio", 77, RATIO_ALARM_O);
        $display("T2 zero delay done");
        smp(8'h52, 1'b0, 5'h00, 5'h00);
        smp(8'h53, 1'b0, 5'h00, 5'h0c);
        smp(8'h5d, 1'b0, 5'h00, 5'h03);
        smp(8'h50, 1'b0, 5'h03, 5'h00);
        chk_val("condition", COND_ALARM, CONDITION_O);
        smp(8'h5f, 1'b0, 5'h00, 5'h03);
        $display("T3 hysteresis done");
        wr(3'h0, 1'b0, 8'h50, 19'h00003);
        tick(2);
        chk_val("exp trip time", 3, EXP_TRIP_TIME_O);
        for (int i = 0; i < 4; i++) begin
            smp(i < 2 ? 8'h5a : 8'h56, 1'b0, 5'h00, 5'h00);
        end
        smp(8'h46, 1'b0, 5'h04, 5'h00);
        chk_val("prefault", 88, PREFAULT_PF_O);
        chk_val("trip left", 3, TRIP_REMAIN_O);
        chk_val("start", 1, START_O);
        smp(8'h46, 1'b0, 5'h00, 5'h00);
        smp(8'h46, 1'b0, 5'h00, 5'h00);
        smp(8'h46, 1'b0, 5'h08, 5'h00);
        smp(8'h5a, 1'b0, 5'h00, 5'h0c);
        $display("T4 definite delay done");
        smp(8'h46, 1'b0, 5'h04, 5'h00);
        smp(8'h46, 1'b1, 5'h10, 5'h04);
        smp(8'h5a, 1'b0, 5'h00, 5'h10);
        smp(8'h46, 1'b1, 5'h10, 5'h00);
        chk_val("condition", COND_BLOCKED, CONDITION_O);
        chk_val("blocked count", 2, CNT_BLOCKED_O);
        smp(8'h5a, 1'b0, 5'h00, 5'h10);
        $display("T5 blocking done");
        for (int m = 1; m <= 5; m++) begin
            LOGICAL_NODE_BEHAVIOUR_I <= m[2:0];
            tick(2);
            chk_val("behaviour", m, LN_BEHAVIOUR_O);
        end
        LOGICAL_NODE_BEHAVIOUR_I <= 3'h1;
        smp(8'h46, 1'b0, 5'h04, 5'h00);
        evq.push_back(10'h004);
        LOGICAL_NODE_BEHAVIOUR_I <= 3'h5;
        tick(3);
        LOGICAL_NODE_BEHAVIOUR_I <= 3'h1;
        smp(8'h5a, 1'b0, 5'h00, 5'h00);
        $display("T6 node behaviour done");
        for (int g = 0; g < 8; g++) begin
            wr(g[2:0], 1'b0, 8'(40 + 5 * g), 19'h00000);
        end
        for (int g = 0; g < 8; g++) begin
            GROUP_SEL_I <= g[2:0];
            p = 81 + $urandom % 19;
            smp(8'(p), 1'b0, 5'h00, 5'h00);
            chk_val("trip ratio", p * 100 / (40 + 5 * g),
                RATIO_TRIP_O);
            chk_val("behaviour", 1, LN_BEHAVIOUR_O);
        end
        $display("T7 setting groups done");
        skip = 1;
        FORCE_STATUS_I <= 3'h2;
        tick(2);
        chk_val("condition", COND_NORMAL, CONDITION_O);
        FORCE_EN_I <= 1'b1;
        for (int s = 1; s <= 5; s++) begin
            FORCE_STATUS_I <= s[2:0];
            tick(2);
            chk_val("condition", s, CONDITION_O);
        end
        FORCE_EN_I <= 1'b0;
        tick(4);
        skip = 0;
        chk_val("trip", 0, TRIP_O);
        $display("T8 forcing done");
        COUNT_CLR_I <= 5'h1f;
        tick(1);
        COUNT_CLR_I <= 5'h00;
        tick(2);
        chk_val("trip count", 0, CNT_TRIP_O);
        chk_val("pending events", 0, evq.size());
        $display("T9 counter clear done");
        final_report();
    end
endmodule // under_power_factor_stage_tb_top
